// ===== rtl/cpip_proc_end.sv
// processor end of the coprocessor instruction port
`timescale 1ns/1ps
module cpip_proc_end
    import cpip_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    cpip_if.proc                    cp,
    input  wire logic               issue_i,        // one-cycle instruction request
    input  wire cpip_pkg::cpip_class_e cls_i,
    input  wire logic [3:0]         cond_i,
    input  wire logic [3:0]         cp_num_i,
    input  wire logic [3:0]         opc_i,
    input  wire logic [2:0]         info_i,
    input  wire logic [3:0]         crd_i,
    input  wire logic [3:0]         crn_i,
    input  wire logic [3:0]         crm_i,
    input  wire logic               long_i,
    input  wire logic               pre_index_i,
    input  wire logic               write_back_i,
    input  wire logic               ofs_neg_i,
    input  wire logic [10:0]        ofs_mag_i,      // byte magnitude
    input  wire logic [3:0]         arm_reg_i,
    input  wire logic [31:0]        reg_value_i,    // processor register or base value
    input  wire logic [31:0]        instr_addr_i,
    input  wire logic [31:0]        status_word_i,  // combined counter and status word
    input  wire logic [3:0]         flags_i,        // N Z C V
    input  wire logic [31:0]        store_data_i,   // memory data for a store
    input  wire logic [31:0]        load_data_i,    // memory data for a load
    output logic                    busy_o,
    output logic                    undef_trap_o,
    output logic                    bad_offset_o,
    output logic                    mem_req_o,
    output logic                    mem_write_o,
    output logic [31:0]             mem_addr_o,
    output logic                    reg_we_o,
    output logic [3:0]              reg_waddr_o,
    output logic [31:0]             reg_wdata_o,
    output logic                    flags_we_o,
    output logic [3:0]              flags_o,
    output logic                    done_o
);
    import cpip_pkg::*;

    // ************************************************************
    // condition evaluation
    // ************************************************************
    // classic 4-bit condition table on the processor's own flags
    function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        logic r;
        n  = f[3];
        z  = f[2];
        cy = f[1];
        v  = f[0];
        unique case (c[3:1])
            3'h0: r = z;
            3'h1: r = cy;
            3'h2: r = n;
            3'h3: r = v;
            3'h4: r = cy & ~z;
            3'h5: r = (n == v);
            3'h6: r = ~z & (n == v);
            3'h7: r = 1'b1;
        endcase
        cond_pass = (c[3:1] == 3'h7) ? ~c[0] | 1'b1 : r ^ c[0];
    endfunction

    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_PROBE, S_XFER} cpip_state_e;
    cpip_state_e state_r;

    logic        pass;
    logic        take;
    logic        ofs_ok;
    logic [31:0] base_val;
    logic [31:0] ofs_val;
    logic [31:0] first_addr;
    logic [31:0] addr_r;
    logic [31:0] start_base_r;
    cpip_class_e cls_r;
    logic [3:0]  arm_reg_r;
    logic        wb_r;
    logic [31:0] mv_word_r;

    assign pass       = cond_pass(cond_i, flags_i);
    // multiple of four and magnitude at most 1020
    assign ofs_ok     = (ofs_mag_i[1:0] == 2'h0) && (ofs_mag_i <= CPIP_OFS_MAX);
    // counter base uses address plus 8 without status flags
    assign base_val   = (arm_reg_i == CPIP_PC_REG) ? instr_addr_i + CPIP_PC_AHEAD
                                                   : reg_value_i;
    assign ofs_val    = ofs_neg_i ? 32'h0 - {21'h0, ofs_mag_i} : {21'h0, ofs_mag_i};
    assign first_addr = pre_index_i ? base_val + ofs_val : base_val;
    // a refused instruction (bad offset, failed condition) never reaches the coprocessor
    assign take       = (state_r == S_IDLE) && issue_i && pass && (cls_i != CPIP_NONE) &&
                        !((cls_i == CPIP_LOAD_MEM || cls_i == CPIP_STORE_MEM) && !ofs_ok);

    // ************************************************************
    // sequencer
    // ************************************************************
    // the instruction is latched at issue; the far end registers presence from the
    // number sent with the request, so it is probed only two cycles after issue
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r      <= S_IDLE;
            cls_r        <= CPIP_NONE;
            arm_reg_r    <= 4'h0;
            wb_r         <= 1'b0;
            addr_r       <= CPIP_WORD_RST;
            start_base_r <= CPIP_WORD_RST;
            mv_word_r    <= CPIP_WORD_RST;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (take) begin
                        state_r      <= S_ISSUE;
                        cls_r        <= cls_i;
                        arm_reg_r    <= arm_reg_i;
                        wb_r         <= write_back_i | ~pre_index_i;
                        addr_r       <= first_addr;
                        start_base_r <= base_val + ofs_val;
                        // counter as source sends the combined word
                        mv_word_r    <= (arm_reg_i == CPIP_PC_REG) ? status_word_i
                                                                   : reg_value_i;
                    end
                end
                // request on the port; presence for its number is not valid yet
                S_ISSUE: begin
                    state_r <= S_PROBE;
                end
                S_PROBE: begin
                    // absent coprocessor ends here; internal op too
                    if (!cp.present || cls_r == CPIP_INTERNAL_OP) begin
                        state_r <= S_IDLE;
                    end else begin
                        state_r <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (cp.last) begin
                        state_r <= S_IDLE;
                    end else begin
                        addr_r <= addr_r + CPIP_WORD_STEP;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // coprocessor side drive
    // ************************************************************
    // fields pass straight through, except opc loses its top bit for moves, so the coprocessor interprets them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cp.req       <= 1'b0;
            cp.cls       <= CPIP_NONE;
            cp.cp_num    <= 4'h0;
            cp.opc       <= 4'h0;
            cp.info      <= 3'h0;
            cp.crd       <= 4'h0;
            cp.crn       <= 4'h0;
            cp.crm       <= 4'h0;
            cp.long_xfer <= 1'b0;
        end else begin
            cp.req <= 1'b0;
            if (take) begin
                cp.req       <= 1'b1;
                cp.cls       <= cls_i;
                cp.cp_num    <= cp_num_i;
                // four-bit op; moves use only three bits
                cp.opc       <= (cls_i == CPIP_MOVE_TO || cls_i == CPIP_MOVE_FROM) ?
                                {1'b0, opc_i[2:0]} : opc_i;
                cp.info      <= info_i;
                cp.crd       <= crd_i;
                cp.crn       <= crn_i;
                cp.crm       <= crm_i;
                cp.long_xfer <= long_i;
            end
        end
    end

    // word strobe and outgoing data during the transfer phase
    always_comb begin
        cp.word_stb = (state_r == S_XFER);
        cp.wdata    = (cls_r == CPIP_LOAD_MEM)  ? load_data_i  :
                      (cls_r == CPIP_STORE_MEM) ? store_data_i : mv_word_r;
    end

    // ************************************************************
    // processor side results
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o       <= 1'b0;
            undef_trap_o <= 1'b0;
            bad_offset_o <= 1'b0;
            mem_req_o    <= 1'b0;
            mem_write_o  <= 1'b0;
            mem_addr_o   <= CPIP_WORD_RST;
            reg_we_o     <= 1'b0;
            reg_waddr_o  <= 4'h0;
            reg_wdata_o  <= CPIP_WORD_RST;
            flags_we_o   <= 1'b0;
            flags_o      <= CPIP_FLAGS_RST;
            done_o       <= 1'b0;
        end else begin
            busy_o       <= (state_r != S_IDLE);
            undef_trap_o <= (state_r == S_PROBE) && !cp.present;
            bad_offset_o <= (state_r == S_IDLE) && issue_i && pass && !ofs_ok &&
                            (cls_i == CPIP_LOAD_MEM || cls_i == CPIP_STORE_MEM);
            mem_req_o    <= 1'b0;
            mem_write_o  <= 1'b0;
            reg_we_o     <= 1'b0;
            flags_we_o   <= 1'b0;
            done_o       <= (state_r == S_PROBE && cp.present && cls_r == CPIP_INTERNAL_OP) ||
                            (state_r == S_XFER && cp.last);
            if (state_r == S_XFER) begin
                if (cls_r == CPIP_LOAD_MEM || cls_r == CPIP_STORE_MEM) begin
                    mem_req_o   <= 1'b1;
                    mem_write_o <= (cls_r == CPIP_STORE_MEM);
                    mem_addr_o  <= addr_r;
                    // base update on the last word; none without it
                    if (cp.last && wb_r) begin
                        reg_we_o    <= 1'b1;
                        reg_waddr_o <= arm_reg_r;
                        reg_wdata_o <= start_base_r;
                    end
                end else if (cls_r == CPIP_MOVE_FROM) begin
                    if (arm_reg_r == CPIP_PC_REG) begin
                        flags_we_o <= 1'b1;
                        flags_o    <= cp.rdata[CPIP_FLAG_HI:CPIP_FLAG_LO];
                    end else begin
                        reg_we_o    <= 1'b1;
                        reg_waddr_o <= arm_reg_r;
                        reg_wdata_o <= cp.rdata;
                    end
                end
            end
        end
    end

endmodule

// ===== inc/cpip_pkg.sv
// package: constants and types shared by the processor end and the coprocessor end
package cpip_pkg;
    // ************************************************************
    // instruction classes
    // ************************************************************
    typedef enum logic [2:0] {
        CPIP_NONE,
        CPIP_INTERNAL_OP,
        CPIP_LOAD_MEM,
        CPIP_STORE_MEM,
        CPIP_MOVE_TO,
        CPIP_MOVE_FROM
    } cpip_class_e;

    // ************************************************************
    // field widths and limits
    // ************************************************************
    localparam int          CPIP_OPC_W       = 4;
    localparam int          CPIP_XFER_OPC_W  = 3;
    localparam int          CPIP_INFO_W      = 3;
    localparam int          CPIP_REG_W       = 4;
    localparam int          CPIP_NUM_W       = 4;
    localparam int          CPIP_COND_W      = 4;
    localparam int          CPIP_OFS_W       = 11;
    localparam logic [31:0] CPIP_WORD_STEP   = 32'h0000_0004;
    localparam logic [31:0] CPIP_PC_AHEAD    = 32'h0000_0008;
    localparam logic [10:0] CPIP_OFS_MAX     = 11'h3fc;
    localparam logic [3:0]  CPIP_PC_REG      = 4'hf;
    localparam int          CPIP_FLAG_HI     = 31;
    localparam int          CPIP_FLAG_LO     = 28;
    localparam logic [3:0]  CPIP_FLAGS_RST   = 4'h0;
    localparam logic [31:0] CPIP_WORD_RST    = 32'h0000_0000;
    localparam logic [25:0] CPIP_PC_MASK     = 26'h3ff_fffc;
endpackage

// ===== inc/cpip_if.sv
// interface: coprocessor port between processor end and coprocessor end
`timescale 1ns/1ps
interface cpip_if;
    import cpip_pkg::*;
    logic                  req;       // one-cycle instruction issue
    cpip_class_e           cls;
    logic [3:0]            cp_num;
    logic [3:0]            opc;       // 4-bit internal op or 3-bit move op in low bits
    logic [2:0]            info;
    logic [3:0]            crd;       // destination / transfer register
    logic [3:0]            crn;
    logic [3:0]            crm;
    logic                  long_xfer;
    logic                  present;   // level, coprocessor cp_num exists
    logic                  word_stb;  // one word moves this cycle
    logic [31:0]           wdata;     // processor to coprocessor
    logic [31:0]           rdata;     // coprocessor to processor
    logic                  last;      // with word_stb: final word
    modport proc (output req, cls, cp_num, opc, info, crd, crn, crm, long_xfer, wdata,
                  output word_stb, input present, rdata, last);
    modport copro (input req, cls, cp_num, opc, info, crd, crn, crm, long_xfer, wdata,
                   input word_stb, output present, rdata, last);
endinterface

// ===== rtl/cpip_copro_end.sv
// coprocessor end of the coprocessor instruction port
`timescale 1ns/1ps
module cpip_copro_end
    import cpip_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    cpip_if.copro                   cp,
    input  wire logic [15:0]        present_map_i,  // which coprocessor numbers exist
    input  wire logic [3:0]         my_num_i,       // own number, always present besides the map
    input  wire logic [3:0]         word_count_i,   // words per memory transfer, less one
    input  wire logic [31:0]        result_i,       // move-from result word
    output logic                    cmd_o,          // one-cycle decoded command
    output cpip_pkg::cpip_class_e   cmd_cls_o,
    output logic [3:0]              cmd_opc_o,
    output logic [2:0]              cmd_info_o,
    output logic [3:0]              cmd_crd_o,
    output logic [3:0]              cmd_crn_o,
    output logic [3:0]              cmd_crm_o,
    output logic                    cmd_long_o,
    output logic                    word_o,         // one received word
    output logic [31:0]             word_data_o
);
    import cpip_pkg::*;

    // ************************************************************
    // command capture
    // ************************************************************
    logic [3:0] left_r;
    logic [3:0] num_r;
    logic       multi_r;

    // presence answered from the map or my_num_i for the number currently requested
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cp.present  <= 1'b0;
            num_r       <= 4'h0;
            cmd_o       <= 1'b0;
            cmd_cls_o   <= CPIP_NONE;
            cmd_opc_o   <= 4'h0;
            cmd_info_o  <= 3'h0;
            cmd_crd_o   <= 4'h0;
            cmd_crn_o   <= 4'h0;
            cmd_crm_o   <= 4'h0;
            cmd_long_o  <= 1'b0;
        end else begin
            cmd_o <= 1'b0;
            cp.present <= present_map_i[cp.cp_num] | (cp.cp_num == my_num_i);
            if (cp.req) begin
                num_r      <= cp.cp_num;
                cmd_o      <= 1'b1;
                cmd_cls_o  <= cp.cls;
                cmd_opc_o  <= cp.opc;
                cmd_info_o <= cp.info;
                cmd_crd_o  <= cp.crd;
                cmd_crn_o  <= cp.crn;
                cmd_crm_o  <= cp.crm;
                cmd_long_o <= cp.long_xfer;
            end
        end
    end

    // ************************************************************
    // word counting: the coprocessor decides the length
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_r      <= 4'h0;
            multi_r     <= 1'b0;
            word_o      <= 1'b0;
            word_data_o <= CPIP_WORD_RST;
        end else begin
            // move-from sends nothing this way, so no word is received then
            word_o <= cp.word_stb && (cp.cls != CPIP_MOVE_FROM);
            if (cp.word_stb && (cp.cls != CPIP_MOVE_FROM)) begin
                word_data_o <= cp.wdata;
            end
            if (cp.req) begin
                multi_r <= (cp.cls == CPIP_LOAD_MEM || cp.cls == CPIP_STORE_MEM);
                left_r  <= word_count_i;
            end else if (cp.word_stb && left_r != 4'h0) begin
                left_r <= left_r - 4'h1;
            end
        end
    end

    // last is combinational on the strobe so the processor stops the same cycle
    always_comb begin
        cp.last  = cp.word_stb && (!multi_r || left_r == 4'h0);
        cp.rdata = result_i;
    end

    logic unused_num;
    assign unused_num = ^num_r;
endmodule

// ===== verification/cpip_port_sva.sv
// checker: protocol properties of the coprocessor port between the two ends
`timescale 1ns/1ps
module cpip_port_sva
    import cpip_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  req,
    input  wire cpip_pkg::cpip_class_e cls,
    input  wire logic [3:0]            cp_num,
    input  wire logic [3:0]            opc,
    input  wire logic [2:0]            info,
    input  wire logic [3:0]            crd,
    input  wire logic [3:0]            crn,
    input  wire logic [3:0]            crm,
    input  wire logic                  long_xfer,
    input  wire logic                  present,
    input  wire logic                  word_stb,
    input  wire logic                  last
);
    // one clock domain, so clocking and reset are given once
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // issue is a pulse, not repeated in the two cycles after it
    a_req_one_pulse: assert property (req |=> !req [*2])
        else $error("issue pulse too long");
    a_req_has_class: assert property (req |-> cls != CPIP_NONE)
        else $error("issue without a class");
    // fields must not move under the far end between issues
    a_fields_hold: assert property (
        !req |-> $stable({cls, cp_num, opc, info, crd, crn, crm, long_xfer}))
        else $error("fields changed without issue");
    a_internal_no_data: assert property (
        req && cls == CPIP_INTERNAL_OP |=> !word_stb [*3])
        else $error("internal op moved data");
    a_word_needs_present: assert property ($rose(word_stb) |-> present)
        else $error("word moved for absent coprocessor");
    a_strobe_after_req: assert property (
        $rose(word_stb) |-> $past(req, 1) || $past(req, 2) || $past(req, 3))
        else $error("word strobe without issue");
    // the far end alone ends a transfer, so the strobe stays until last
    a_strobe_until_last: assert property (word_stb && !last |=> word_stb)
        else $error("transfer stopped before last");
    a_last_in_strobe: assert property (last |-> word_stb)
        else $error("last outside a word");
    a_move_one_word: assert property (
        word_stb && (cls == CPIP_MOVE_TO || cls == CPIP_MOVE_FROM) |-> last)
        else $error("move longer than one word");
    a_move_opc_narrow: assert property (
        req && (cls == CPIP_MOVE_TO || cls == CPIP_MOVE_FROM) |-> !opc[3])
        else $error("move opcode wider than three bits");
endmodule

// ===== verification/cpip_tb.sv
// testbench: both port ends joined, random instructions checked against a queue model
`timescale 1ns/1ps
module cpip_tb;
    import cpip_pkg::*;
    logic        clk_i, rst_n_i, issue_i, long_i, pre_index_i, write_back_i, ofs_neg_i;
    cpip_class_e cls_i, cmd_cls_o;
    logic [3:0]  cond_i, cp_num_i, opc_i, crd_i, crn_i, crm_i, arm_reg_i, flags_i;
    logic [3:0]  my_num_i, word_count_i, reg_waddr_o, flags_o;
    logic [3:0]  cmd_opc_o, cmd_crd_o, cmd_crn_o, cmd_crm_o;
    logic [2:0]  info_i, cmd_info_o, end_code;
    logic [10:0] ofs_mag_i;
    logic [15:0] present_map_i;
    logic [31:0] reg_value_i, instr_addr_i, status_word_i, store_data_i, load_data_i;
    logic [31:0] result_i, mem_addr_o, reg_wdata_o, word_data_o;
    logic        busy_o, undef_trap_o, bad_offset_o, mem_req_o, mem_write_o, reg_we_o;
    logic        flags_we_o, done_o, cmd_o, cmd_long_o, word_o;
    int          mismatches, samples_checked, cycles, ends;
    logic [32:0] mem_q[$];
    logic [35:0] wr_q[$];
    logic [31:0] word_q[$];
    logic [3:0]  fl_q[$];
    logic [22:0] cmd_q[$];

    cpip_if cp_bus ();
    cpip_proc_end cpip_proc_end_inst (.clk_i, .rst_n_i, .cp(cp_bus), .issue_i, .cls_i, .cond_i,
        .cp_num_i, .opc_i, .info_i, .crd_i, .crn_i, .crm_i, .long_i, .pre_index_i, .write_back_i,
        .ofs_neg_i, .ofs_mag_i, .arm_reg_i, .reg_value_i, .instr_addr_i, .status_word_i, .flags_i,
        .store_data_i, .load_data_i, .busy_o, .undef_trap_o, .bad_offset_o, .mem_req_o,
        .mem_write_o, .mem_addr_o, .reg_we_o, .reg_waddr_o, .reg_wdata_o, .flags_we_o, .flags_o,
        .done_o);
    cpip_copro_end cpip_copro_end_inst (.clk_i, .rst_n_i, .cp(cp_bus), .present_map_i, .my_num_i,
        .word_count_i, .result_i, .cmd_o, .cmd_cls_o, .cmd_opc_o, .cmd_info_o, .cmd_crd_o,
        .cmd_crn_o, .cmd_crm_o, .cmd_long_o, .word_o, .word_data_o);
    cpip_port_sva cpip_port_sva_inst (.clk_i, .rst_n_i, .req(cp_bus.req), .cls(cp_bus.cls),
        .cp_num(cp_bus.cp_num), .opc(cp_bus.opc), .info(cp_bus.info), .crd(cp_bus.crd),
        .crn(cp_bus.crn), .crm(cp_bus.crm), .long_xfer(cp_bus.long_xfer),
        .present(cp_bus.present), .word_stb(cp_bus.word_stb), .last(cp_bus.last));

    // ************************************************************
    // clock, event collector and watchdog
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // pulses last one cycle, so each is seen at exactly one edge
    always @(posedge clk_i) begin
        cycles++;
        if (mem_req_o) mem_q.push_back({mem_write_o, mem_addr_o});
        if (reg_we_o) wr_q.push_back({reg_waddr_o, reg_wdata_o});
        if (flags_we_o) fl_q.push_back(flags_o);
        if (word_o) word_q.push_back(word_data_o);
        if (cmd_o) cmd_q.push_back({cmd_cls_o, cmd_opc_o, cmd_info_o, cmd_crd_o, cmd_crn_o,
                                    cmd_crm_o, cmd_long_o});
        if (done_o || undef_trap_o || bad_offset_o) begin
            ends++;
            end_code = {done_o, undef_trap_o, bad_offset_o};
        end
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // only always, equal and not-equal are generated; Z is flag bit 2
    function automatic bit cond_ok(input logic [3:0] c, input logic [3:0] f);
        case (c)
            4'h0: return f[2];
            4'h1: return !f[2];
            default: return 1'b1;
        endcase
    endfunction

    // ************************************************************
    // one random instruction, issued and checked against the model
    // ************************************************************
    task automatic run_op(input int i);
        logic [31:0] base, wb, addr;
        logic [22:0] e, m;
        logic [2:0]  exp_end;
        bit          mem, mv, pres;
        int          n, nw;
        cls_i = cpip_class_e'(3'($urandom_range(5, 1)));
        cond_i = ($urandom_range(3) == 0) ? 4'($urandom_range(1)) : 4'he;
        {flags_i, cp_num_i, opc_i, crd_i, crn_i, crm_i, arm_reg_i, my_num_i} = 32'($urandom);
        {info_i, long_i, ofs_neg_i} = 5'($urandom);
        pre_index_i = (arm_reg_i == 4'hf) | 1'($urandom);
        write_back_i = (arm_reg_i != 4'hf) & 1'($urandom);
        case ($urandom_range(5))
            0: ofs_mag_i = 11'h3fc;
            1: ofs_mag_i = 11'h400;
            2: ofs_mag_i = 11'h002 | 11'($urandom_range(255) << 2);
            default: ofs_mag_i = 11'($urandom_range(255) << 2);
        endcase
        present_map_i = 16'($urandom);
        word_count_i = 4'($urandom_range(3));
        {reg_value_i, instr_addr_i, status_word_i} = {$urandom, $urandom, $urandom};
        {store_data_i, load_data_i, result_i} = {$urandom, $urandom, $urandom};
        // model of the processor end
        mem = (cls_i == CPIP_LOAD_MEM) || (cls_i == CPIP_STORE_MEM);
        mv = (cls_i == CPIP_MOVE_TO) || (cls_i == CPIP_MOVE_FROM);
        pres = present_map_i[cp_num_i] || (my_num_i == cp_num_i);
        base = (arm_reg_i == 4'hf) ? instr_addr_i + 32'h8 : reg_value_i;
        wb = ofs_neg_i ? base - 32'(ofs_mag_i) : base + 32'(ofs_mag_i);
        addr = pre_index_i ? wb : base;
        exp_end = !cond_ok(cond_i, flags_i) ? 3'b000 :
                  (mem && (ofs_mag_i > 11'h3fc || ofs_mag_i[1:0] != 2'h0)) ? 3'b001 :
                  !pres ? 3'b010 : 3'b100;
        mem_q.delete();
        wr_q.delete();
        word_q.delete();
        fl_q.delete();
        cmd_q.delete();
        {ends, end_code} = '0;
        issue_i = 1'b1;
        @(posedge clk_i);
        #1 issue_i = 1'b0;
        n = 0;
        while (ends == 0 && n < 12) begin
            @(posedge clk_i);
            #1 n++;
        end
        repeat (2) @(posedge clk_i);
        #1;
        check(ends, exp_end != 3'b000);
        check(end_code, exp_end);
        check(busy_o, 1'b0);
        n = (exp_end == 3'b100 && mem) ? int'(word_count_i) + 1 : 0;
        check(mem_q.size(), n);
        for (int k = 0; k < n && k < mem_q.size(); k++)
            check(mem_q[k], {cls_i == CPIP_STORE_MEM, addr + 32'(4 * k)});
        // every loaded word reaches the coprocessor as one received word
        if (cls_i == CPIP_LOAD_MEM) check(word_q.size(), n);
        if (cls_i == CPIP_LOAD_MEM && n > 0 && word_q.size() > 0)
            check(word_q[0], load_data_i);
        nw = (exp_end == 3'b100 && ((mem && (!pre_index_i || write_back_i))
              || (cls_i == CPIP_MOVE_FROM && arm_reg_i != 4'hf))) ? 1 : 0;
        check(wr_q.size(), nw);
        if (nw == 1 && wr_q.size() == 1)
            check(wr_q[0], {arm_reg_i, mem ? wb : result_i});
        nw = (exp_end == 3'b100 && cls_i == CPIP_MOVE_FROM && arm_reg_i == 4'hf) ? 1 : 0;
        check(fl_q.size(), nw);
        if (nw == 1 && fl_q.size() == 1) check(fl_q[0], result_i[31:28]);
        if (exp_end == 3'b100 && !mem)
            check(word_q.size(), cls_i == CPIP_MOVE_TO);
        if (exp_end == 3'b100 && cls_i == CPIP_MOVE_TO && word_q.size() == 1)
            check(word_q[0], (arm_reg_i == 4'hf) ? status_word_i : reg_value_i);
        // compare only the fields each class carries to the far end
        e = {cls_i, mv ? {1'b0, opc_i[2:0]} : opc_i, info_i, crd_i, crn_i, crm_i, long_i};
        m = mem ? {3'h7, 7'h00, 4'hf, 8'h00, 1'b1} :
            mv ? {3'h7, 4'hf, 3'h7, 4'h0, 8'hff, 1'b0} : {22'h3fffff, 1'b0};
        check(cmd_q.size(), exp_end[2] | exp_end[1]);
        if (exp_end == 3'b100 && cmd_q.size() == 1)
            check(cmd_q[0] & m, e & m);
        $display("test %0d class %0d outcome %b done", i, cls_i, exp_end);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // reset, then back-to-back random instructions
    initial begin
        void'($urandom(32'haad9bed9));
        {rst_n_i, issue_i, long_i, pre_index_i, write_back_i, ofs_neg_i} = '0;
        {cond_i, cp_num_i, opc_i, crd_i, crn_i, crm_i, arm_reg_i, flags_i} = '0;
        {my_num_i, word_count_i, info_i, ofs_mag_i, present_map_i} = '0;
        {reg_value_i, instr_addr_i, status_word_i, store_data_i, load_data_i, result_i} = '0;
        cls_i = CPIP_NONE;
        repeat (5) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        for (int i = 0; i < 120; i++) run_op(i);
        tally_and_finish();
    end
endmodule
